// ---- adcc_top.sv ----
// adcc_top: control, compare and result registers of a SAR converter
// assumes a single-cycle byte register port and a core with start/done handshake
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ns
module adcc_top
(
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // register port
  input  wire logic [7:0]             reg_addr,
  input  wire logic [7:0]             reg_wr_data,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic [7:0]                  reg_rd_data,
  // converter core
  input  wire logic                   hw_trigger,
  input  wire logic                   ext_clk_tick,
  input  wire adcc_pkg::adcc_sar_out_s sar_out,
  output logic                        sar_start,
  output logic                        conv_tick,
  output adcc_pkg::adcc_core_cfg_s    core_cfg,
  // interrupt
  output logic                        irq
);

  typedef struct packed {
    logic        trig_sel;
    logic        cmp_en;
    logic        cmp_gt;
    logic [1:0]  ref_sel;
    logic [11:0] cmp_val;
    logic [7:0]  config_b;
    logic        cont;
    logic [1:0]  ev_st;
    logic [1:0]  ev_msk;
    logic [7:0]  rdata;
    logic        start;
    logic        active;
    logic        irq;
  } adcc_top_s;

  adcc_top_s   st_reg;
  adcc_top_s   st_next;
  logic [11:0] result;
  logic        complete;
  logic        div_tick;

  adcc_clkdiv u_div
  (
    .clk                (clk),
    .rst_n              (rst_n),
    .clock_source_field (st_reg.config_b[adcc_pkg::ADCC_POS_CLKSRC +: 2]),
    .clock_divide_field (st_reg.config_b[adcc_pkg::ADCC_POS_DIV +: 2]),
    .ext_tick           (ext_clk_tick),
    .conv_tick          (div_tick)
  );

  // compare value feeds the match test
  adcc_result u_res
  (
    .clk                    (clk),
    .rst_n                  (rst_n),
    .sar                    (sar_out),
    .resolution             (st_reg.config_b[adcc_pkg::ADCC_POS_MODE +: 2]),
    .compare_enable         (st_reg.cmp_en),
    .compare_greater_select (st_reg.cmp_gt),
    .compare_value          (st_reg.cmp_val),
    .result                 (result),
    .complete               (complete)
  );

  always_comb
  begin
    logic       wr_c2;
    logic       sw_go;
    logic       hw_go;
    logic       re_go;
    logic [1:0] ev_set;
    logic [1:0] ev_clr;
    wr_c2   = reg_wr && reg_addr == adcc_pkg::ADCC_OFS_CTRL2;
    sw_go   = 1'b0;
    hw_go   = 1'b0;
    re_go   = 1'b0;
    ev_set  = 2'h0;
    ev_clr  = 2'h0;
    st_next = st_reg;
    st_next.start = 1'b0;

    // register writes; result addresses have no write path
    // result bytes absent here
    if (reg_wr)
    begin
      case (reg_addr)
        adcc_pkg::ADCC_OFS_CTRL2:
        begin
          st_next.trig_sel = reg_wr_data[adcc_pkg::ADCC_POS_TRIG];
          st_next.cmp_en   = reg_wr_data[adcc_pkg::ADCC_POS_CMP_EN];
          st_next.cmp_gt   = reg_wr_data[adcc_pkg::ADCC_POS_CMP_GT];
          st_next.ref_sel  = reg_wr_data[adcc_pkg::ADCC_POS_REF +: 2];
        end
        adcc_pkg::ADCC_OFS_CMP_HI: st_next.cmp_val[11:8] = reg_wr_data[3:0];
        adcc_pkg::ADCC_OFS_CMP_LO: st_next.cmp_val[7:0] = reg_wr_data;
        adcc_pkg::ADCC_OFS_CONFIG: st_next.config_b = reg_wr_data;
        adcc_pkg::ADCC_OFS_IRQ_ST: ev_clr = reg_wr_data[1:0];
        adcc_pkg::ADCC_OFS_IRQ_MSK: st_next.ev_msk = reg_wr_data[1:0];
        adcc_pkg::ADCC_OFS_RUN: st_next.cont = reg_wr_data[adcc_pkg::ADCC_POS_CONT];
        default:
        begin
          st_next.cont = st_reg.cont;
        end
      endcase
    end

    // software start follows the written select bit
    sw_go = wr_c2 && !reg_wr_data[adcc_pkg::ADCC_POS_TRIG];
    hw_go = hw_trigger && st_reg.trig_sel;
    // continuous mode rearms itself under the software trigger; in compare mode a match does not stop it
    re_go = sar_out.done && st_reg.cont && !st_reg.trig_sel;

    if (sar_out.done)
    begin
      st_next.active = 1'b0;
    end
    if ((sw_go || hw_go || re_go) && (!st_reg.active || sar_out.done) && !st_reg.start)
    begin
      st_next.start  = 1'b1;
      st_next.active = 1'b1;
    end
    else if (hw_go)
    begin
      // a trigger during a conversion is dropped; flag it
      ev_set[adcc_pkg::ADCC_POS_EV_LOST] = 1'b1;
    end

    // done event after every capture; in compare mode only after a matched one
    ev_set[adcc_pkg::ADCC_POS_EV_DONE] = ev_set[adcc_pkg::ADCC_POS_EV_DONE] | complete;
    // set beats a clear in the same cycle
    st_next.ev_st = (st_reg.ev_st & ~ev_clr) | ev_set;
    st_next.irq   = |(st_next.ev_st & st_next.ev_msk);

    // read data one cycle later; unmapped reads zero
    st_next.rdata = adcc_pkg::ADCC_RST_BYTE;
    if (reg_rd)
    begin
      case (reg_addr)
        adcc_pkg::ADCC_OFS_CTRL2:
          st_next.rdata = {st_reg.active, st_reg.trig_sel, st_reg.cmp_en,
                           st_reg.cmp_gt, 2'h0, st_reg.ref_sel};
        adcc_pkg::ADCC_OFS_RES_HI: st_next.rdata = {4'h0, result[11:8]};
        adcc_pkg::ADCC_OFS_RES_LO: st_next.rdata = result[7:0];
        adcc_pkg::ADCC_OFS_CMP_HI: st_next.rdata = {4'h0, st_reg.cmp_val[11:8]};
        adcc_pkg::ADCC_OFS_CMP_LO: st_next.rdata = st_reg.cmp_val[7:0];
        adcc_pkg::ADCC_OFS_CONFIG: st_next.rdata = st_reg.config_b;
        adcc_pkg::ADCC_OFS_IRQ_ST: st_next.rdata = {6'h0, st_reg.ev_st};
        adcc_pkg::ADCC_OFS_IRQ_MSK: st_next.rdata = {6'h0, st_reg.ev_msk};
        adcc_pkg::ADCC_OFS_RUN: st_next.rdata = {7'h0, st_reg.cont};
        default: st_next.rdata = adcc_pkg::ADCC_RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // settings to the core, all from flops
  // fields passed through
  assign core_cfg.low_power_conversion = st_reg.config_b[adcc_pkg::ADCC_POS_LOWPWR];
  assign core_cfg.long_sample_select   = st_reg.config_b[adcc_pkg::ADCC_POS_LONG];
  assign core_cfg.resolution           = st_reg.config_b[adcc_pkg::ADCC_POS_MODE +: 2];
  assign core_cfg.clock_source_field   = st_reg.config_b[adcc_pkg::ADCC_POS_CLKSRC +: 2];
  assign core_cfg.reference_select     = st_reg.ref_sel;
  assign sar_start   = st_reg.start;
  assign conv_tick   = div_tick;
  assign reg_rd_data = st_reg.rdata;
  assign irq         = st_reg.irq;

  a_hw_start_go: assert property (@(posedge clk) disable iff (!rst_n)
    (hw_trigger && st_reg.trig_sel && !st_reg.active && !sar_start) |=> sar_start)
    else $error("hardware trigger did not start a conversion");

  a_sw_start_go: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_wr && reg_addr == 8'h31 && !reg_wr_data[6] && !st_reg.active && !sar_start)
    |=> sar_start ##1 !sar_start)
    else $error("software write did not start one conversion");

  a_sw_no_start: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_wr && reg_addr == 8'h31 && reg_wr_data[6] && !hw_trigger && !sar_out.done)
    |=> !sar_start)
    else $error("software write started a hardware-trigger conversion");

  a_ref_select: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_wr && reg_addr == 8'h31) |=> core_cfg.reference_select == $past(reg_wr_data[1:0]))
    else $error("reference select not driven from the written field");

  a_mode_bits: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_wr && reg_addr == 8'h31) |=> (st_reg.cmp_en == $past(reg_wr_data[5])
      && st_reg.cmp_gt == $past(reg_wr_data[4])))
    else $error("compare mode bits not stored");

  a_result_ro: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_wr && (reg_addr == 8'h32 || reg_addr == 8'h33) && !sar_out.done)
    |=> $stable(result))
    else $error("write changed the result");

  a_cmp_high_write: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_wr && reg_addr == 8'h34) |=> (st_reg.cmp_val[11:8] == $past(reg_wr_data[3:0])
      && $stable(st_reg.cmp_val[7:0])))
    else $error("compare high write wrong");

  a_cmp_readback: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_rd && reg_addr == 8'h34 && !reg_wr) |=> reg_rd_data == {4'h0, $past(st_reg.cmp_val[11:8])})
    else $error("compare high readback wrong");

  a_res_high_read: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_rd && reg_addr == 8'h32) |=> reg_rd_data == {4'h0, $past(result[11:8])})
    else $error("result high byte layout wrong");

  a_done_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    (complete && st_reg.ev_msk[0] && !(reg_wr && reg_addr == adcc_pkg::ADCC_OFS_IRQ_MSK))
    |=> (st_reg.ev_st[0] && irq))
    else $error("completion flag or interrupt wrong");

  a_lost_flag: assert property (@(posedge clk) disable iff (!rst_n)
    (hw_trigger && st_reg.trig_sel && st_reg.active && !sar_out.done) |=> st_reg.ev_st[1])
    else $error("dropped trigger not flagged");

  a_cmp_low_write: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_wr && reg_addr == adcc_pkg::ADCC_OFS_CMP_LO) |=> (st_reg.cmp_val[7:0] == $past(reg_wr_data)
      && $stable(st_reg.cmp_val[11:8])))
    else $error("compare low write wrong");

  a_cmp_low_read: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_rd && reg_addr == adcc_pkg::ADCC_OFS_CMP_LO) |=> reg_rd_data == $past(st_reg.cmp_val[7:0]))
    else $error("compare low readback wrong");

  a_res_low_read: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_rd && reg_addr == adcc_pkg::ADCC_OFS_RES_LO) |=> reg_rd_data == $past(result[7:0]))
    else $error("result low byte wrong");

  a_mode_out: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_wr && reg_addr == adcc_pkg::ADCC_OFS_CONFIG)
    |=> core_cfg.resolution == $past(reg_wr_data[adcc_pkg::ADCC_POS_MODE +: 2]))
    else $error("resolution not passed to the core");

  a_src_out: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_wr && reg_addr == adcc_pkg::ADCC_OFS_CONFIG)
    |=> core_cfg.clock_source_field == $past(reg_wr_data[adcc_pkg::ADCC_POS_CLKSRC +: 2]))
    else $error("clock source not passed to the core");

  a_operand_less: assert property (@(posedge clk) disable iff (!rst_n)
    (complete && $past(st_reg.cmp_en) && !$past(st_reg.cmp_gt)) |-> result < $past(st_reg.cmp_val))
    else $error("less-than capture without a match");

  a_operand_more: assert property (@(posedge clk) disable iff (!rst_n)
    (complete && $past(st_reg.cmp_en) && $past(st_reg.cmp_gt)) |-> result > $past(st_reg.cmp_val))
    else $error("greater-than capture without a match");

  a_start_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    sar_start |=> !sar_start)
    else $error("start pulse longer than one cycle");

  a_trig_store: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_wr && reg_addr == adcc_pkg::ADCC_OFS_CTRL2)
    |=> st_reg.trig_sel == $past(reg_wr_data[adcc_pkg::ADCC_POS_TRIG]))
    else $error("trigger select not stored");

  c_hw_conv: cover property (@(posedge clk) disable iff (!rst_n)
    sar_start && st_reg.trig_sel ##[1:200] sar_out.done);

  c_cmp_match: cover property (@(posedge clk) disable iff (!rst_n)
    complete && st_reg.cmp_en);

  c_irq_raise: cover property (@(posedge clk) disable iff (!rst_n)
    $rose(irq));

  c_cont_rearm: cover property (@(posedge clk) disable iff (!rst_n)
    sar_out.done && st_reg.cont ##1 sar_start);

endmodule

// ---- adcc_pkg.sv ----
// adcc_pkg: register map, field layout and carriers for the converter control block
// assumes an 8-bit register port and a converter core that returns 12-bit results
package adcc_pkg;

  // register offsets
  localparam logic [7:0] ADCC_OFS_CTRL2   = 8'h31;
  localparam logic [7:0] ADCC_OFS_RES_HI  = 8'h32;
  localparam logic [7:0] ADCC_OFS_RES_LO  = 8'h33;
  localparam logic [7:0] ADCC_OFS_CMP_HI  = 8'h34;
  localparam logic [7:0] ADCC_OFS_CMP_LO  = 8'h35;
  localparam logic [7:0] ADCC_OFS_CONFIG  = 8'h36;
  localparam logic [7:0] ADCC_OFS_IRQ_ST  = 8'h38;
  localparam logic [7:0] ADCC_OFS_IRQ_MSK = 8'h39;
  localparam logic [7:0] ADCC_OFS_RUN     = 8'h3a;

  // conv_status_control_two fields
  localparam int ADCC_POS_ACTIVE  = 7;
  localparam int ADCC_POS_TRIG    = 6;
  localparam int ADCC_POS_CMP_EN  = 5;
  localparam int ADCC_POS_CMP_GT  = 4;
  localparam int ADCC_POS_REF     = 0;

  // converter_config fields
  localparam int ADCC_POS_LOWPWR  = 7;
  localparam int ADCC_POS_DIV     = 5;
  localparam int ADCC_POS_LONG    = 4;
  localparam int ADCC_POS_MODE    = 2;
  localparam int ADCC_POS_CLKSRC  = 0;

  // run control and interrupt fields
  localparam int ADCC_POS_CONT    = 0;
  localparam int ADCC_POS_EV_DONE = 0;
  localparam int ADCC_POS_EV_LOST = 1;

  // reset values
  localparam logic [7:0]  ADCC_RST_BYTE = 8'h00;
  localparam logic [11:0] ADCC_RST_WORD = 12'h000;

  // resolution codes
  localparam logic [1:0] ADCC_MODE_8  = 2'h0;
  localparam logic [1:0] ADCC_MODE_12 = 2'h1;

  // clock source codes
  localparam logic [1:0] ADCC_SRC_BUS  = 2'h0;
  localparam logic [1:0] ADCC_SRC_HALF = 2'h1;

  // settings handed to the converter core
  typedef struct packed {
    logic       low_power_conversion;
    logic       long_sample_select;
    logic [1:0] resolution;
    logic [1:0] clock_source_field;
    logic [1:0] reference_select;
  } adcc_core_cfg_s;

  // result of one conversion from the core
  typedef struct packed {
    logic        done;
    logic [11:0] data;
  } adcc_sar_out_s;

endpackage

// ---- adcc_clkdiv.sv ----
// adcc_clkdiv: converter clock enable from the selected source and divide ratio
// assumes ext_tick is a one-cycle pulse already in the clk domain
`timescale 1ns/1ns
module adcc_clkdiv
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // selection
  input  wire logic [1:0] clock_source_field,
  input  wire logic [1:0] clock_divide_field,
  input  wire logic       ext_tick,
  // enable out
  output logic            conv_tick
);

  typedef struct packed {
    logic       half;
    logic [2:0] cnt;
    logic       tick;
    logic [3:0] sel;
  } adcc_div_s;

  adcc_div_s st_reg;
  adcc_div_s st_next;

  always_comb
  begin
    logic       base_en;
    logic [2:0] limit;
    base_en = 1'b0;
    limit   = 3'h0;
    st_next = st_reg;
    st_next.half = ~st_reg.half;
    st_next.tick = 1'b0;
    st_next.sel  = {clock_source_field, clock_divide_field};
    case (clock_source_field)
      adcc_pkg::ADCC_SRC_BUS:  base_en = 1'b1;
      adcc_pkg::ADCC_SRC_HALF: base_en = st_reg.half;
      default:                 base_en = ext_tick;
    endcase
    limit = 3'((4'h1 << clock_divide_field) - 4'h1);
    // restart the count on a new setting so no short period escapes
    if (st_next.sel != st_reg.sel)
    begin
      st_next.cnt = 3'h0;
    end
    else if (base_en)
    begin
      if (st_reg.cnt >= limit)
      begin
        st_next.cnt  = 3'h0;
        st_next.tick = 1'b1;
      end
      else
      begin
        st_next.cnt = st_reg.cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign conv_tick = st_reg.tick;

  a_div_eight_gap: assert property (@(posedge clk) disable iff (!rst_n)
    (conv_tick && clock_divide_field == 2'h3) |=> !conv_tick [*7])
    else $error("divide by 8 tick came early");

  a_bus_full_rate: assert property (@(posedge clk) disable iff (!rst_n)
    (clock_source_field == 2'h0 && clock_divide_field == 2'h0 && $stable(st_reg.sel)
     && $past(clock_source_field) == 2'h0 && $past(clock_divide_field) == 2'h0)
    |=> conv_tick)
    else $error("bus clock divide by 1 missed a tick");

endmodule

// ---- adcc_result.sv ----
// adcc_result: result capture, justification and compare test
// assumes the core returns its result MSB-aligned in 12 bits
`timescale 1ns/1ns
module adcc_result
(
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // from the core
  input  wire adcc_pkg::adcc_sar_out_s sar,
  // settings
  input  wire logic [1:0]             resolution,
  input  wire logic                   compare_enable,
  input  wire logic                   compare_greater_select,
  input  wire logic [11:0]            compare_value,
  // outputs
  output logic [11:0]                 result,
  output logic                        complete
);

  typedef struct packed {
    logic [11:0] res;
    logic        done;
  } adcc_res_s;

  adcc_res_s st_reg;
  adcc_res_s st_next;
  logic [11:0] just;
  logic        match;

  always_comb
  begin
    case (resolution)
      adcc_pkg::ADCC_MODE_8:  just = {4'h0, sar.data[11:4]};
      adcc_pkg::ADCC_MODE_12: just = sar.data;
      default:                just = {2'h0, sar.data[11:2]};
    endcase
    if (compare_greater_select)
    begin
      match = just > compare_value;
    end
    else
    begin
      match = just < compare_value;
    end
    st_next = st_reg;
    st_next.done = 1'b0;
    // capture on every done, or in compare mode only on a true compare
    if (sar.done && (!compare_enable || match))
    begin
      st_next.res  = just;
      st_next.done = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign result   = st_reg.res;
  assign complete = st_reg.done;

  a_no_false_done: assert property (@(posedge clk) disable iff (!rst_n)
    (sar.done && compare_enable && !match) |=> (!complete && $stable(result)))
    else $error("completion without compare match");

  a_capture_value: assert property (@(posedge clk) disable iff (!rst_n)
    (sar.done && !compare_enable && resolution == 2'h1)
    |=> (complete && result == $past(sar.data)))
    else $error("result not captured at conversion end");

  a_justify_eight: assert property (@(posedge clk) disable iff (!rst_n)
    (sar.done && !compare_enable && resolution == 2'h0)
    |=> result == {4'h0, $past(sar.data[11:4])})
    else $error("8-bit result not right-justified");

  a_hold_result: assert property (@(posedge clk) disable iff (!rst_n)
    !sar.done |=> $stable(result))
    else $error("result changed without a capture");

endmodule

// ---- adcc_core_model.sv ----
// adcc_core_model: behavioural converter core that answers each start with a result
// assumes one-cycle start pulses and counts its work in converter clock ticks
`timescale 1ns/1ns
module adcc_core_model
(
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // to and from the block
  input  wire logic               sar_start,
  input  wire logic               conv_tick,
  output adcc_pkg::adcc_sar_out_s sar_out,
  // bench control and status
  input  wire logic [11:0]        conv_data,
  input  wire logic [3:0]         conv_ticks,
  output logic                    busy,
  output logic [7:0]              starts
);
  logic [3:0] left;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      busy    <= 1'b0;
      left    <= 4'h0;
      starts  <= 8'h00;
      sar_out <= '0;
    end
    else
    begin
      sar_out.done <= 1'b0;
      // data is only valid with done; toggle so a stale sample shows up
      sar_out.data <= ~sar_out.data;
      if (sar_start)
      begin
        busy   <= 1'b1;
        left   <= conv_ticks;
        starts <= starts + 8'h01;
      end
      else if (busy && conv_tick)
      begin
        if (left == 4'h0)
        begin
          busy         <= 1'b0;
          sar_out.done <= 1'b1;
          sar_out.data <= conv_data;
        end
        else
          left <= left - 4'h1;
      end
    end
  end
endmodule

// ---- tb_adcc_top.sv ----
// tb_adcc_top: register-level tests of the converter control block
// assumes the core model answers every start after a few converter ticks
`timescale 1ns/1ns
module tb_adcc_top;
  logic                     clk;
  logic                     rst_n;
  logic [7:0]               reg_addr;
  logic [7:0]               reg_wr_data;
  logic                     reg_wr;
  logic                     reg_rd;
  logic [7:0]               reg_rd_data;
  logic                     hw_trigger;
  logic                     ext_clk_tick;
  adcc_pkg::adcc_sar_out_s  sar_out;
  logic                     sar_start;
  logic                     conv_tick;
  adcc_pkg::adcc_core_cfg_s core_cfg;
  logic                     irq;
  logic [11:0]              cdata;
  logic                     busy;
  logic [7:0]               starts;
  logic [7:0]               s0;
  logic [7:0]               zero_addrs [7];
  logic [35:0]              cmp_tab [5];
  logic [15:0]              tick_tab [8];
  int                       failures;
  int                       n_checks;
  int                       cycles;

  adcc_top uut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rd_data(reg_rd_data), .hw_trigger(hw_trigger),
    .ext_clk_tick(ext_clk_tick), .sar_out(sar_out), .sar_start(sar_start),
    .conv_tick(conv_tick), .core_cfg(core_cfg), .irq(irq));

  adcc_core_model core (.clk(clk), .rst_n(rst_n), .sar_start(sar_start),
    .conv_tick(conv_tick), .sar_out(sar_out), .conv_data(cdata), .conv_ticks(4'h3),
    .busy(busy), .starts(starts));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic summarize;
    if (failures == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // whole run is a little over a thousand cycles; this ceiling only catches a hang
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      summarize;
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr    <= a;
    reg_wr_data <= d;
    reg_wr      <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    // callers look at registered state only once it has settled
    @(negedge clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rd_data;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk({8'h00, d}, {8'h00, exp});
  endtask

  // both result bytes; high byte upper nibble must read zero
  task automatic rdres(input logic [11:0] exp);
    logic [7:0] hi;
    logic [7:0] lo;
    rd(8'h32, hi);
    rd(8'h33, lo);
    chk({hi, lo}, {4'h0, exp});
  endtask

  task automatic settle;
    int i;
    repeat (3) @(posedge clk);
    for (i = 0; i < 200 && busy; i++)
      @(posedge clk);
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic conv(input logic [7:0] ctrl, input logic [11:0] d);
    cdata <= d;
    wr(adcc_pkg::ADCC_OFS_CTRL2, ctrl);
    settle;
  endtask

  task automatic trig;
    @(posedge clk);
    hw_trigger <= 1'b1;
    @(posedge clk);
    hw_trigger <= 1'b0;
  endtask

  task automatic ticks(input logic [7:0] cfg, input logic [7:0] exp);
    int i;
    logic [7:0] n;
    wr(8'h36, cfg);
    n = 8'h00;
    for (i = 0; i < 80; i++)
    begin
      @(posedge clk);
      ext_clk_tick <= (i % 4 == 0);
      @(negedge clk);
      if (i >= 16 && conv_tick === 1'b1)
        n++;
    end
    chk({8'h00, n}, {8'h00, exp});
    chk({10'h000, core_cfg[7:2]}, {10'h000, cfg[7], cfg[4], cfg[3:2], cfg[1:0]});
  endtask

  function automatic logic [11:0] just(input logic [11:0] d, input logic [1:0] m);
    case (m)
      2'h0:    return {4'h0, d[11:4]};
      2'h1:    return d;
      default: return {2'h0, d[11:2]};
    endcase
  endfunction

  initial
  begin
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wr_data = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    hw_trigger = 1'b0;
    ext_clk_tick = 1'b0;
    cdata = 12'h000;
    failures = 0;
    n_checks = 0;
    cycles = 0;
    zero_addrs = '{8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h3f};
    // control, core data, expected result, expected done flag
    cmp_tab = '{{8'h20, 12'h200, 12'h5c3, 4'h0}, {8'h20, 12'h0f0, 12'h0f0, 4'h1},
                {8'h30, 12'h050, 12'h0f0, 4'h0}, {8'h30, 12'h100, 12'h0f0, 4'h0},
                {8'h30, 12'h3c4, 12'h3c4, 4'h1}};
    // config value, converter ticks seen in 64 cycles
    tick_tab = '{16'h9440, 16'h2420, 16'h4410, 16'h6408,
                 16'h0520, 16'h2608, 16'h0710, 16'h0440};
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    foreach (zero_addrs[i]) rdchk(zero_addrs[i], 8'h00);
    chk({8'h00, core_cfg}, 16'h0000);
    wr(8'h34, 8'hff);
    wr(8'h35, 8'ha5);
    rdchk(8'h34, 8'h0f);
    rdchk(8'h35, 8'ha5);
    wr(8'h34, 8'h31);
    rdchk(8'h34, 8'h01);
    wr(8'h35, 8'h00);
    rdchk(8'h35, 8'h00);
    wr(adcc_pkg::ADCC_OFS_IRQ_MSK, 8'h01);
    for (int m = 0; m < 4; m++)
    begin
      wr(8'h36, 8'(m << 2));
      chk({14'h0, core_cfg.resolution}, 16'(m));
      conv(8'h00, 12'hab7);
      rdres(just(12'hab7, 2'(m)));
      chk({15'h0, irq}, 16'h0001);
      rdchk(adcc_pkg::ADCC_OFS_IRQ_ST, 8'h01);
      wr(adcc_pkg::ADCC_OFS_IRQ_ST, 8'h01);
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk({15'h0, irq}, 16'h0000);
    end
    wr(8'h32, 8'hff);
    wr(8'h33, 8'h00);
    rdres(12'h2ad);
    wr(8'h36, 8'h04);
    for (int r = 0; r < 4; r++)
    begin
      conv(8'(r), 12'h5c3);
      chk({14'h0, core_cfg.reference_select}, 16'(r));
      rdchk(adcc_pkg::ADCC_OFS_CTRL2, 8'(r));
    end
    wr(adcc_pkg::ADCC_OFS_IRQ_ST, 8'h03);
    foreach (cmp_tab[i])
    begin
      conv(cmp_tab[i][35:28], cmp_tab[i][27:16]);
      rdres(cmp_tab[i][15:4]);
      rdchk(adcc_pkg::ADCC_OFS_IRQ_ST, {4'h0, cmp_tab[i][3:0]});
      chk({15'h0, irq}, {12'h0, cmp_tab[i][3:0]});
      wr(adcc_pkg::ADCC_OFS_IRQ_ST, 8'h01);
    end
    s0 = starts;
    cdata <= 12'h777;
    wr(adcc_pkg::ADCC_OFS_CTRL2, 8'h40);
    wr(adcc_pkg::ADCC_OFS_CTRL2, 8'h40);
    settle;
    chk({8'h00, starts}, {8'h00, s0});
    trig;
    settle;
    chk({8'h00, starts}, {8'h00, s0 + 8'h01});
    rdres(12'h777);
    wr(adcc_pkg::ADCC_OFS_IRQ_ST, 8'h01);
    trig;
    trig;
    settle;
    chk({8'h00, starts}, {8'h00, s0 + 8'h02});
    rdchk(adcc_pkg::ADCC_OFS_IRQ_ST, 8'h03);
    wr(adcc_pkg::ADCC_OFS_IRQ_MSK, 8'h00);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk({15'h0, irq}, 16'h0000);
    wr(adcc_pkg::ADCC_OFS_IRQ_MSK, 8'h02);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk({15'h0, irq}, 16'h0001);
    wr(adcc_pkg::ADCC_OFS_IRQ_ST, 8'h03);
    rdchk(adcc_pkg::ADCC_OFS_IRQ_ST, 8'h00);
    chk({15'h0, irq}, 16'h0000);
    // continuous compare keeps converting but stays silent until a match
    s0 = starts;
    wr(adcc_pkg::ADCC_OFS_RUN, 8'h01);
    conv(8'h20, 12'h200);
    chk({15'h0, starts > s0 + 8'h01}, 16'h0001);
    rdres(12'h777);
    rdchk(adcc_pkg::ADCC_OFS_IRQ_ST, 8'h00);
    cdata <= 12'h050;
    settle;
    rdres(12'h050);
    rdchk(adcc_pkg::ADCC_OFS_IRQ_ST, 8'h01);
    wr(adcc_pkg::ADCC_OFS_RUN, 8'h00);
    settle;
    foreach (tick_tab[i]) ticks(tick_tab[i][15:8], tick_tab[i][7:0]);
    summarize;
  end
endmodule
